//--- verilog/adcc_pkg.sv
// Purpose: Shared constants and types for the converter control block
// Assumes: 32-bit AXI4-Lite register bus, one clock
// Notes:   Register offsets are indices; byte address is four times the index
package adcc_pkg;

    // ************************************************************
    // Register indices
    // ************************************************************
    localparam logic [7:0] IDX_RESULT_HIGH = 8'hc4;
    localparam logic [7:0] IDX_RESULT_LOW  = 8'hc5;
    localparam logic [7:0] IDX_MODE        = 8'hc6;
    localparam logic [7:0] IDX_START_STAT  = 8'hc7;
    localparam logic [7:0] IDX_IRQ_STATUS  = 8'hc8;
    localparam logic [7:0] IDX_IRQ_MASK    = 8'hc9;

    // ************************************************************
    // Field positions and fixed read values
    // ************************************************************
    localparam int         MODE_PERIOD_BIT  = 7;
    localparam int         MODE_TRIG_BIT    = 6;
    localparam int         STAT_FLAG_BIT    = 7;
    localparam int         IRQ_DONE_BIT     = 0;
    localparam logic [7:0] MODE_RSVD_ONES   = 8'h30;
    localparam logic [7:0] STAT_RSVD_ONES   = 8'h7f;
    localparam logic [3:0] CHAN_SEL_RESET   = 4'h0;
    localparam logic [3:0] CHAN_FIRST_CODE  = 4'h4;
    localparam logic [1:0] CHAN_NONE_UPPER  = 2'h0;
    localparam logic [7:0] IRQ_FIELD_MASK   = 8'h01;

    // ************************************************************
    // Conversion periods in system clock cycles
    // ************************************************************
    localparam int         PERIOD_LONG_CYC  = 62;
    localparam int         PERIOD_SHORT_CYC = 31;

    // ************************************************************
    // Bus answers
    // ************************************************************
    localparam logic [1:0] RESP_OKAY        = 2'h0;
    localparam logic [1:0] RESP_SLVERR      = 2'h2;

    // ************************************************************
    // Types
    // ************************************************************
    typedef enum logic {
        ADCC_IDLE,
        ADCC_CONVERT
    } adcc_state_t;

    typedef struct packed {
        logic       chan_enable;
        logic [3:0] chan_index;
        logic       sampling;
        logic       start_pulse;
    } adcc_core_ctrl_t;

endpackage

//--- verilog/adcc_top.sv
// Purpose: Converter control with AXI4-Lite registers and a done interrupt
// Assumes: ext_trigger_pin and core data synchronous to aclk
// Notes:   Core result must be valid when the period count ends
//
// The AXI4-Lite register port was left to the implementer.

module adcc_top #(
    parameter int ADDR_W      = 12,
    parameter int LONG_CYC    = adcc_pkg::PERIOD_LONG_CYC,
    parameter int SHORT_CYC   = adcc_pkg::PERIOD_SHORT_CYC
) (
    input  wire logic                      aclk,
    input  wire logic                      aresetn,
    input  wire logic [ADDR_W-1:0]         s_axi_awaddr,
    input  wire logic                      s_axi_awvalid,
    output logic                           s_axi_awready,
    input  wire logic [31:0]               s_axi_wdata,
    input  wire logic [3:0]                s_axi_wstrb,
    input  wire logic                      s_axi_wvalid,
    output logic                           s_axi_wready,
    output logic [1:0]                     s_axi_bresp,
    output logic                           s_axi_bvalid,
    input  wire logic                      s_axi_bready,
    input  wire logic [ADDR_W-1:0]         s_axi_araddr,
    input  wire logic                      s_axi_arvalid,
    output logic                           s_axi_arready,
    output logic [31:0]                    s_axi_rdata,
    output logic [1:0]                     s_axi_rresp,
    output logic                           s_axi_rvalid,
    input  wire logic                      s_axi_rready,
    input  wire logic                      ext_trigger_pin,
    input  wire logic [9:0]                core_result,
    output adcc_pkg::adcc_core_ctrl_t      core_ctrl,
    output logic                           irq
);
    import adcc_pkg::*;

    // ************************************************************
    // Elaboration checks
    // ************************************************************
    if (ADDR_W < 10 || ADDR_W > 32) begin : g_bad_addr_w
        $error("adcc_top: ADDR_W must lie in 10 to 32");
    end
    if (LONG_CYC < 2 || LONG_CYC > 255) begin : g_bad_long_cyc
        $error("adcc_top: LONG_CYC must lie in 2 to 255");
    end
    if (SHORT_CYC < 2 || SHORT_CYC > 255) begin : g_bad_short_cyc
        $error("adcc_top: SHORT_CYC must lie in 2 to 255");
    end

    // ************************************************************
    // Functions
    // ************************************************************
    function automatic logic [7:0] word_index(input logic [ADDR_W-1:0] addr);
        logic [ADDR_W-1:0] shifted;
        shifted = addr >> 2;
        word_index = shifted[7:0];
    endfunction

    function automatic logic addr_ok(input logic [ADDR_W-1:0] addr);
        logic [ADDR_W-1:0] shifted;
        shifted = addr >> 2;
        addr_ok = (addr[1:0] == 2'h0) && (shifted[ADDR_W-1:8] == '0)
                  && (shifted[7:0] >= IDX_RESULT_HIGH) && (shifted[7:0] <= IDX_IRQ_MASK);
    endfunction

    function automatic logic chan_live(input logic [3:0] code);
        chan_live = (code[3:2] != CHAN_NONE_UPPER);
    endfunction

    // ************************************************************
    // Registers
    // ************************************************************
    logic                      period_sel_r;
    logic                      ext_trigger_enable_r;
    logic [3:0]                chan_sel_r;
    logic [7:0]                result_high_r;
    logic [7:0]                result_low_r;
    logic [7:0]                irq_status_r;
    logic [7:0]                irq_mask_r;
    logic                      trig_prev_r;
    logic [7:0]                count_r;
    adcc_state_t               state_r;
    logic                      start_pulse_r;
    logic                      bvalid_r;
    logic [1:0]                bresp_r;
    logic                      rvalid_r;
    logic [1:0]                rresp_r;
    logic [31:0]               rdata_r;
    logic                      aw_full_r;
    logic [ADDR_W-1:0]         awaddr_r;
    logic                      w_full_r;
    logic [31:0]               wdata_r;
    logic [3:0]                wstrb_r;
    logic                      chan_on_r;
    logic [3:0]                chan_idx_r;

    logic                      wr_fire;
    logic                      rd_fire;
    logic [7:0]                wr_idx;
    logic                      wr_ok;
    logic                      wr_lane0;
    logic                      wr_stat;
    logic                      trig_edge;
    logic                      start_req;
    logic                      abort_req;
    logic                      conv_done;
    logic [7:0]                period_last;
    logic [7:0]                rd_nxt;
    logic                      aw_take;
    logic                      w_take;
    logic                      aw_have;
    logic                      w_have;
    logic [ADDR_W-1:0]         wr_addr;
    logic [31:0]               wr_data;
    logic [3:0]                wr_strb;

    // ************************************************************
    // Bus handshakes
    // ************************************************************
    assign s_axi_awready = !aw_full_r && !bvalid_r;
    assign s_axi_wready  = !w_full_r && !bvalid_r;
    assign s_axi_arready = !rvalid_r;
    assign aw_take       = s_axi_awvalid && s_axi_awready;
    assign w_take        = s_axi_wvalid && s_axi_wready;
    assign aw_have       = aw_full_r || aw_take;
    assign w_have        = w_full_r || w_take;
    assign wr_fire       = aw_have && w_have && !bvalid_r;
    assign rd_fire       = s_axi_arvalid && !rvalid_r;
    assign wr_addr       = aw_full_r ? awaddr_r : s_axi_awaddr;
    assign wr_data       = w_full_r ? wdata_r : s_axi_wdata;
    assign wr_strb       = w_full_r ? wstrb_r : s_axi_wstrb;
    assign wr_idx        = word_index(wr_addr);
    assign wr_ok         = addr_ok(wr_addr);
    assign wr_lane0      = wr_fire && wr_ok && wr_strb[0];
    assign wr_stat       = wr_lane0 && (wr_idx == IDX_START_STAT);
    assign s_axi_bvalid  = bvalid_r;
    assign s_axi_bresp   = bresp_r;
    assign s_axi_rvalid  = rvalid_r;
    assign s_axi_rresp   = rresp_r;
    assign s_axi_rdata   = rdata_r;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_r <= 1'b0;
            bresp_r  <= RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_r <= 1'b1;
            bresp_r  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_r <= 1'b0;
        end
    end

    // ************************************************************
    // Write channel holding
    // ************************************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_r <= 1'b0;
            awaddr_r  <= '0;
        end else if (wr_fire) begin
            aw_full_r <= 1'b0;
        end else if (aw_take) begin
            aw_full_r <= 1'b1;
            awaddr_r  <= s_axi_awaddr;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_full_r <= 1'b0;
            wdata_r  <= 32'h0000_0000;
            wstrb_r  <= 4'h0;
        end else if (wr_fire) begin
            w_full_r <= 1'b0;
        end else if (w_take) begin
            w_full_r <= 1'b1;
            wdata_r  <= s_axi_wdata;
            wstrb_r  <= s_axi_wstrb;
        end
    end

    // ************************************************************
    // Read data
    // ************************************************************
    always_comb begin
        rd_nxt = 8'h00;
        unique case (word_index(s_axi_araddr))
            IDX_RESULT_HIGH: rd_nxt = result_high_r;
            IDX_RESULT_LOW:  rd_nxt = result_low_r;
            IDX_MODE:        rd_nxt = {period_sel_r, ext_trigger_enable_r, 2'b00, chan_sel_r} | MODE_RSVD_ONES;
            IDX_START_STAT:  rd_nxt = {(state_r == ADCC_CONVERT), 7'h00} | STAT_RSVD_ONES;
            IDX_IRQ_STATUS:  rd_nxt = irq_status_r;
            IDX_IRQ_MASK:    rd_nxt = irq_mask_r;
            default:         rd_nxt = 8'h00;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_r <= 1'b0;
            rresp_r  <= RESP_OKAY;
            rdata_r  <= 32'h0000_0000;
        end else if (rd_fire) begin
            rvalid_r <= 1'b1;
            rresp_r  <= addr_ok(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
            rdata_r  <= addr_ok(s_axi_araddr) ? {24'h00_0000, rd_nxt} : 32'h0000_0000;
        end else if (s_axi_rready) begin
            rvalid_r <= 1'b0;
        end
    end

    // ************************************************************
    // Mode register
    // ************************************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            period_sel_r         <= 1'b0;
            ext_trigger_enable_r <= 1'b0;
            chan_sel_r           <= CHAN_SEL_RESET;
        end else if (wr_lane0 && wr_idx == IDX_MODE) begin
            period_sel_r         <= wr_data[MODE_PERIOD_BIT];
            ext_trigger_enable_r <= wr_data[MODE_TRIG_BIT];
            chan_sel_r           <= wr_data[3:0];
        end
    end

    // ************************************************************
    // Conversion sequencing
    // ************************************************************
    assign trig_edge   = ext_trigger_enable_r && (ext_trigger_pin != trig_prev_r);
    assign start_req   = (wr_stat && wr_data[STAT_FLAG_BIT]) || trig_edge;
    assign abort_req   = wr_stat && !wr_data[STAT_FLAG_BIT];
    assign period_last = period_sel_r ? 8'(SHORT_CYC - 1) : 8'(LONG_CYC - 1);
    assign conv_done   = (state_r == ADCC_CONVERT) && (count_r == period_last) && !start_req && !abort_req;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            trig_prev_r <= 1'b0;
        end else begin
            trig_prev_r <= ext_trigger_pin;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_r       <= ADCC_IDLE;
            count_r       <= 8'h00;
            start_pulse_r <= 1'b0;
        end else begin
            start_pulse_r <= start_req;
            unique case (state_r)
                ADCC_IDLE: begin
                    if (start_req) begin
                        state_r <= ADCC_CONVERT;
                        count_r <= 8'h00;
                    end
                end
                ADCC_CONVERT: begin
                    if (start_req) begin
                        count_r <= 8'h00;
                    end else if (abort_req) begin
                        state_r <= ADCC_IDLE;
                    end else if (conv_done) begin
                        state_r <= ADCC_IDLE;
                    end else begin
                        count_r <= count_r + 8'h01;
                    end
                end
            endcase
        end
    end

    // ************************************************************
    // Result registers
    // ************************************************************
    always_ff @(posedge aclk) begin
        if (conv_done) begin
            result_high_r <= core_result[9:2];
            result_low_r  <= {core_result[1:0], 6'h00};
        end
    end

    // ************************************************************
    // Interrupt status and mask
    // ************************************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_status_r <= 8'h00;
        end else begin
            if (wr_lane0 && wr_idx == IDX_IRQ_STATUS) begin
                irq_status_r <= irq_status_r & ~(wr_data[7:0] & IRQ_FIELD_MASK);
            end
            if (conv_done) begin
                irq_status_r[IRQ_DONE_BIT] <= 1'b1;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_mask_r <= 8'h00;
        end else if (wr_lane0 && wr_idx == IDX_IRQ_MASK) begin
            irq_mask_r <= wr_data[7:0] & IRQ_FIELD_MASK;
        end
    end

    assign irq = |(irq_status_r & irq_mask_r);

    // ************************************************************
    // Core control
    // ************************************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            chan_on_r  <= 1'b0;
            chan_idx_r <= 4'h0;
        end else begin
            chan_on_r  <= chan_live(chan_sel_r);
            chan_idx_r <= chan_live(chan_sel_r) ? (chan_sel_r - CHAN_FIRST_CODE) : 4'h0;
        end
    end

    assign core_ctrl = '{
        chan_enable: chan_on_r,
        chan_index:  chan_idx_r,
        sampling:    (state_r == ADCC_CONVERT),
        start_pulse: start_pulse_r
    };

endmodule

//--- testbench/adcc_monitor.sv
// Purpose: Port checks for adcc_top
// Assumes: One clock, reset active low
// Notes:   Bound to adcc_top at file foot
module adcc_monitor #(
    parameter int LONG_CYC = 62
) (
    input wire logic                      aclk,
    input wire logic                      aresetn,
    input wire logic                      s_axi_awvalid,
    input wire logic                      s_axi_wvalid,
    input wire logic                      s_axi_awready,
    input wire logic                      s_axi_wready,
    input wire logic [1:0]                s_axi_bresp,
    input wire logic                      s_axi_bvalid,
    input wire logic                      s_axi_bready,
    input wire logic                      s_axi_arvalid,
    input wire logic                      s_axi_arready,
    input wire logic [31:0]               s_axi_rdata,
    input wire logic                      s_axi_rvalid,
    input wire logic                      s_axi_rready,
    input wire adcc_pkg::adcc_core_ctrl_t core_ctrl
);
    import adcc_pkg::*;
    int run_r;
    // Cycles since the last start
    always_ff @(posedge aclk) run_r <= !aresetn ? 0 : core_ctrl.start_pulse ? 1 : run_r + 1;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    property p_no_chan; !core_ctrl.chan_enable |-> core_ctrl.chan_index == 4'h0; endproperty
    a_no_chan: assert property (p_no_chan) else $error("index set with no channel");
    property p_chan_rng; core_ctrl.chan_enable |-> core_ctrl.chan_index <= 4'hb; endproperty
    a_chan_rng: assert property (p_chan_rng) else $error("channel index out of range");
    property p_start; $rose(core_ctrl.sampling) |-> core_ctrl.start_pulse; endproperty
    a_start: assert property (p_start) else $error("sampling without start");
    property p_busy; core_ctrl.start_pulse && !(s_axi_awvalid && s_axi_awready) && !(s_axi_wvalid && s_axi_wready)
        |-> core_ctrl.sampling ##1 core_ctrl.sampling; endproperty
    a_busy: assert property (p_busy) else $error("start without sampling");
    property p_len; core_ctrl.sampling && !core_ctrl.start_pulse |-> run_r < LONG_CYC; endproperty
    a_len: assert property (p_len) else $error("conversion too long");
    property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
    a_bhold: assert property (p_bhold) else $error("write answer dropped");
    property p_wans; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid; endproperty
    a_wans: assert property (p_wans) else $error("write answer late");
    property p_rans; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
    a_rans: assert property (p_rans) else $error("read answer late");
    property p_rhold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
    a_rhold: assert property (p_rhold) else $error("read answer dropped");
endmodule
bind adcc_top adcc_monitor #(.LONG_CYC(LONG_CYC)) u_mon (.*);

//--- testbench/adcc_core_model.sv
// Purpose: Converter core stand-in
// Assumes: Level held during a conversion
// Notes:   Output flips each cycle when idle
module adcc_core_model (
    input  wire logic                      aclk,
    input  wire adcc_pkg::adcc_core_ctrl_t core_ctrl,
    input  wire logic [9:0]                level,
    output logic      [9:0]                core_result
);
    import adcc_pkg::*;
    initial core_result = 10'h000;
    always @(posedge aclk) core_result <= core_ctrl.sampling ? level : ~core_result;
endmodule

//--- testbench/adcc_top_tb.sv
// Purpose: Self-checking bench for adcc_top
// Assumes: Documented conversion periods
// Notes:   Bus answers checked from queues
module adcc_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import adcc_pkg::*;
    // Software duty; bench clock too fast for it
    localparam int LC = PERIOD_LONG_CYC;
    localparam int SC = PERIOD_SHORT_CYC;
    logic            aclk = 1'h0, aresetn = 1'h0, awv = 1'h0, wv = 1'h0, br = 1'h0, arv = 1'h0, rr = 1'h0;
    logic            pin = 1'h0, bv, rv, awr, wrdy, arr, irq;
    logic [11:0]     awa = 12'h0, ara = 12'h0;
    logic [31:0]     wd = 32'h0, rdat, seed = 32'hb4a762dc;
    logic [1:0]      bresp, rresp;
    logic [9:0]      lvl = 10'h0, keep, cres;
    adcc_core_ctrl_t cc;
    logic [33:0]     exp_r[$];
    logic [1:0]      exp_b[$];
    int              errors = 0, cmp_count = 0, last_len = 0, run = 0;
    always #25 aclk = ~aclk;
    adcc_top #(.LONG_CYC(LC), .SHORT_CYC(SC)) u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa),
        .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv),
        .s_axi_wready(wrdy), .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ara),
        .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
        .s_axi_rready(rr), .ext_trigger_pin(pin), .core_result(cres), .core_ctrl(cc), .irq(irq));
    adcc_core_model u_core (.aclk(aclk), .core_ctrl(cc), .level(lvl), .core_result(cres));
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input logic [33:0] got, input logic [33:0] exp);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Answer monitor and conversion length meter
    always @(posedge aclk) begin
        if (rv && rr) chk({rresp, rdat}, exp_r.pop_front());
        if (bv && br) chk({32'h0, bresp}, {32'h0, exp_b.pop_front()});
        run <= cc.sampling ? run + 1 : 0;
        if (!cc.sampling && run != 0) last_len <= run;
    end
    task automatic wait_on(input int w);
        for (int n = 0; n < 200; n++) begin
            @(posedge aclk);
            if (w == 0 ? awr && wrdy : w == 1 ? bv : w == 2 ? arr : w == 3 ? rv : w == 4 ? cc.sampling : !cc.sampling)
                return;
        end
        errors++;
        summarize();
    endtask
    task automatic wr(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] er = RESP_OKAY);
        exp_b.push_back(er);
        awa <= {2'h0, idx, 2'h0};
        wd <= {24'h0, d};
        {awv, wv, br} <= 3'h7;
        wait_on(0);
        {awv, wv} <= 2'h0;
        wait_on(1);
        br <= 1'h0;
        @(posedge aclk);
    endtask
    task automatic rd(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] er = RESP_OKAY);
        exp_r.push_back({er, 24'h0, d});
        ara <= {2'h0, idx, 2'h0};
        {arv, rr} <= 2'h3;
        wait_on(2);
        arv <= 1'h0;
        wait_on(3);
        rr <= 1'h0;
        @(posedge aclk);
    endtask
    task automatic conv(input logic sel, input logic [3:0] code);
        lvl <= 10'(rnd());
        wr(IDX_MODE, {sel, 3'h3, code});
        wr(IDX_START_STAT, 8'h80);
        if (!sel) rd(IDX_START_STAT, 8'hff);
        wait_on(5);
        @(posedge aclk);
        chk(34'(last_len), 34'(sel ? SC : LC));
        rd(IDX_START_STAT, 8'h7f);
        rd(IDX_RESULT_HIGH, lvl[9:2]);
        rd(IDX_RESULT_LOW, {lvl[1:0], 6'h0});
    endtask
    initial begin
        repeat (5) @(posedge aclk);
        aresetn <= 1'h1;
        rd(IDX_MODE, MODE_RSVD_ONES);
        rd(IDX_START_STAT, STAT_RSVD_ONES);
        rd(IDX_IRQ_MASK, 8'h00);
        $display("test reset done");
        for (int c = 0; c < 16; c++) begin
            wr(IDX_MODE, {4'h3, 4'(c)});
            chk({33'h0, cc.chan_enable}, {33'h0, c > 3});
            chk(34'(cc.chan_index), c > 3 ? 34'(c - 4) : 34'h0);
            rd(IDX_MODE, {4'h3, 4'(c)});
        end
        $display("test channel done");
        wr(IDX_IRQ_MASK, 8'h01);
        conv(1'h0, 4'h4);
        chk({33'h0, irq}, 34'h1);
        rd(IDX_IRQ_STATUS, 8'h01);
        wr(IDX_IRQ_STATUS, 8'h01);
        chk({33'h0, irq}, 34'h0);
        conv(1'h1, 4'hf);
        wr(IDX_IRQ_MASK, 8'h00);
        chk({33'h0, irq}, 34'h0);
        rd(IDX_IRQ_STATUS, 8'h01);
        $display("test conversion done");
        wr(IDX_RESULT_HIGH, 8'h5a);
        rd(IDX_RESULT_HIGH, lvl[9:2]);
        rd(8'h10, 8'h00, RESP_SLVERR);
        wr(8'h10, 8'h00, RESP_SLVERR);
        wr(IDX_IRQ_STATUS, 8'h01);
        keep = lvl;
        lvl <= ~lvl;
        wr(IDX_START_STAT, 8'h80);
        wr(IDX_START_STAT, 8'h00);
        repeat (LC) @(posedge aclk);
        chk({33'h0, cc.sampling}, 34'h0);
        rd(IDX_IRQ_STATUS, 8'h00);
        rd(IDX_RESULT_HIGH, keep[9:2]);
        $display("test abort done");
        wr(IDX_MODE, 8'h34);
        pin <= 1'h1;
        repeat (4) @(posedge aclk);
        chk({33'h0, cc.sampling}, 34'h0);
        wr(IDX_MODE, 8'h74);
        pin <= 1'h0;
        wait_on(4);
        wait_on(5);
        @(posedge aclk);
        chk(34'(last_len), 34'(LC));
        pin <= 1'h1;
        wait_on(4);
        $display("test trigger done");
        summarize();
    end
endmodule
